//--- core/lcs_scan_sequencer.sv
// Timing sequencer that scans two LC sensors, with register port and interrupt.
//
// What this block does
// R1: Top five bits of each state word give that state's duration count.
// R2: On expiry step to the next state word until a stop state ends scan.
// R3: Scan end raises stop flag; auto-repeat waits one sampling period, restarts.
// R4: Without auto-repeat, a scan starts only on a software trigger.
// R5: The first state aligns to an auxiliary clock rising edge.
// R6: Second state excites channel 0 for five sense-oscillator cycles, analog off.
// R7: After excitation one auxiliary period with analog off lets the sensor ring.
// R8: Consecutive one-cycle fast-clock states add up to a tunable extra delay.
// R9: Settling state powers comparator and DAC for its programmed duration.
// R10: Latch state captures comparator result of current channel into storage.
// R11: Two damping states short the sensor for two auxiliary periods, analog off.
// R12: A second state group repeats the channel 0 steps up to the latch for channel 1, with no damping states.
// R13: A state holding only the stop bit completes the scan cycle.
// R14: Optional inversion of the comparator output detects troughs instead of peaks.
// R15: Two threshold registers per channel give upper and lower references.
// R16: Software raises the repeat rate during recalibration, not this block.
// R17: Result low selects the upper threshold; result high selects the lower.
// R18: Between scans the sequencer idles with all analog controls off.
//
// Decided for this implementation: strobed register access and the address map.
module lcs_scan_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic aux_clk_in,
  input wire logic sense_osc_clock,
  input wire logic fast_sense_clock,
  input wire logic comparator_in,
  output lcs_pkg::lcs_analog_t analog_out,
  output logic latch_strobe,
  output logic scan_stop,
  output logic [1:0] chan_result,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 4;

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_q1_r;
  logic [NSYNC-1:0] sync_q2_r;
  logic [NSYNC-1:0] sync_q3_r;
  logic [NSYNC-1:0] filt_r;
  logic [NSYNC-1:0] filt_prev_r;
  logic [NSYNC-1:0] rise;

  assign sync_in = {comparator_in, fast_sense_clock, sense_osc_clock, aux_clk_in};

  // Edges are ignored until the pipeline holds real pin levels.
  // Otherwise the reset value of the filter would pose as a rising edge.
  localparam int NPRIME = 6;

  logic [NPRIME-1:0] prime_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prime_r <= '0;
    end else begin
      prime_r <= {prime_r[NPRIME-2:0], 1'b1};
    end
  end

  // A level only counts once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync_q1_r[gi] <= 1'b0;
          sync_q2_r[gi] <= 1'b0;
          sync_q3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
          filt_prev_r[gi] <= 1'b0;
        end else begin
          sync_q1_r[gi] <= sync_in[gi];
          sync_q2_r[gi] <= sync_q1_r[gi];
          sync_q3_r[gi] <= sync_q2_r[gi];
          if (sync_q2_r[gi] == sync_q3_r[gi]) begin
            filt_r[gi] <= sync_q3_r[gi];
          end
          filt_prev_r[gi] <= filt_r[gi];
        end
      end
      assign rise[gi] = prime_r[NPRIME-1] & filt_r[gi] & ~filt_prev_r[gi];
    end
  endgenerate

  logic aux_rise;
  logic osc_rise;
  logic fast_rise;
  logic comp_level;

  assign aux_rise = rise[0];
  assign osc_rise = rise[1];
  assign fast_rise = rise[2];
  assign comp_level = filt_r[3];

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [15:0] state_mem_r [0:lcs_pkg::NUM_STATES-1];
  logic [15:0] ctrl_r;
  logic [15:0] period_r;
  logic [11:0] lower_r [0:lcs_pkg::NUM_CHAN-1];
  logic [11:0] upper_r [0:lcs_pkg::NUM_CHAN-1];
  logic [2:0] evt_status_r;
  logic [2:0] irq_en_r;

  logic wr_state;
  logic trigger;
  logic [2:0] evt_clr;
  logic [2:0] evt_set;

  // Word addresses 0x00 to 0x1F all map onto the state word table.
  function automatic logic is_state_addr(input logic [7:0] a);
    is_state_addr = (a[7:5] == lcs_pkg::ADDR_STATE_BASE[7:5]);
  endfunction

  assign wr_state = reg_wr && is_state_addr(reg_addr);
  assign trigger = reg_wr && (reg_addr == lcs_pkg::ADDR_TRIGGER) && reg_wdata[lcs_pkg::TRIG_START];
  assign evt_clr = (reg_wr && (reg_addr == lcs_pkg::ADDR_IRQ_CLR)) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < lcs_pkg::NUM_STATES; i++) begin
        state_mem_r[i] <= lcs_pkg::STATE_RST[i];
      end
    end else if (wr_state) begin
      state_mem_r[reg_addr[4:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= lcs_pkg::CTRL_RST;
      period_r <= lcs_pkg::PERIOD_RST;
      irq_en_r <= lcs_pkg::EVT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        lcs_pkg::ADDR_CTRL: begin
          ctrl_r <= reg_wdata;
        end
        lcs_pkg::ADDR_PERIOD: begin
          period_r <= reg_wdata;
        end
        lcs_pkg::ADDR_IRQ_EN: begin
          irq_en_r <= reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Two references per channel form the analog hysteresis window.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int c = 0; c < lcs_pkg::NUM_CHAN; c++) begin
        lower_r[c] <= lcs_pkg::DAC_RST;
        upper_r[c] <= lcs_pkg::DAC_RST;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        lcs_pkg::ADDR_LOWER0: lower_r[0] <= reg_wdata[11:0]; // [R15]
        lcs_pkg::ADDR_UPPER0: upper_r[0] <= reg_wdata[11:0]; // [R15]
        lcs_pkg::ADDR_LOWER1: lower_r[1] <= reg_wdata[11:0]; // [R15]
        lcs_pkg::ADDR_UPPER1: upper_r[1] <= reg_wdata[11:0]; // [R15]
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  lcs_pkg::lcs_seq_t seq_r;
  logic [4:0] idx_r;
  logic [4:0] cnt_r;
  logic [15:0] wait_cnt_r;
  logic [1:0] result_r;
  lcs_pkg::lcs_state_word_t cur;
  logic tick;
  logic expire;
  logic at_stop;
  logic scan_end;
  logic restart;
  logic comp_sample;

  assign cur = lcs_pkg::lcs_state_word_t'(state_mem_r[idx_r]);

  // Aux states count aux edges, so state 0 ends on an aux rising edge. [R5]
  // Excite and latch states count the sense oscillator, other hf_clk_sel states the fast clock.
  always_comb begin
    if (cur.aux_clk_sel) begin
      tick = aux_rise; // [R5] [R7] [R11]
    end else if (cur.hf_clk_sel) begin
      tick = (cur.excite || cur.latch_en) ? osc_rise : fast_rise; // [R6] [R8] [R9] [R10]
    end else begin
      tick = 1'b1;
    end
  end

  assign expire = (seq_r == lcs_pkg::SEQ_RUN) && tick && (cnt_r == cur.duration); // [R1]
  assign at_stop = (seq_r == lcs_pkg::SEQ_RUN) && cur.stop; // [R13]
  assign scan_end = at_stop || (expire && (idx_r == 5'h1F));
  assign restart = ctrl_r[lcs_pkg::CTRL_ENABLE] && (ctrl_r[lcs_pkg::CTRL_AUTO] || trigger); // [R4]
  assign comp_sample = comp_level ^ ctrl_r[lcs_pkg::CTRL_INVERT]; // [R14]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_r <= lcs_pkg::SEQ_IDLE;
    end else begin
      case (seq_r)
        lcs_pkg::SEQ_IDLE: begin
          if (restart) begin
            seq_r <= lcs_pkg::SEQ_RUN; // [R18]
          end
        end
        lcs_pkg::SEQ_RUN: begin
          if (scan_end) begin
            seq_r <= ctrl_r[lcs_pkg::CTRL_AUTO] ? lcs_pkg::SEQ_WAIT : lcs_pkg::SEQ_IDLE; // [R3] [R4]
          end
        end
        lcs_pkg::SEQ_WAIT: begin
          if (!ctrl_r[lcs_pkg::CTRL_ENABLE] || !ctrl_r[lcs_pkg::CTRL_AUTO]) begin
            seq_r <= lcs_pkg::SEQ_IDLE;
          end else if (aux_rise && (wait_cnt_r >= period_r)) begin
            seq_r <= lcs_pkg::SEQ_RUN; // [R3]
          end
        end
        default: begin
          seq_r <= lcs_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // State index and duration counter; every scan begins at the first word.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_r <= lcs_pkg::IDX_RST;
      cnt_r <= lcs_pkg::CNT_RST;
    end else if (seq_r != lcs_pkg::SEQ_RUN || scan_end) begin
      idx_r <= lcs_pkg::IDX_RST; // [R3]
      cnt_r <= lcs_pkg::CNT_RST;
    end else if (expire) begin
      idx_r <= idx_r + 5'h01; // [R2] [R12]
      cnt_r <= lcs_pkg::CNT_RST;
    end else if (tick) begin
      cnt_r <= cnt_r + 5'h01; // [R1] [R8]
    end
  end

  // Sampling period timer, counted in auxiliary clock edges.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt_r <= 16'h0000;
    end else if (seq_r != lcs_pkg::SEQ_WAIT) begin
      wait_cnt_r <= 16'h0000;
    end else if (aux_rise) begin
      wait_cnt_r <= wait_cnt_r + 16'h0001; // [R3]
    end
  end

  // Comparator result is captured at the last tick of a latch state.
  logic latch_now;
  assign latch_now = expire && cur.latch_en;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_r <= 2'h0;
    end else if (latch_now) begin
      result_r[cur.chan[0]] <= comp_sample; // [R10] [R12]
    end
  end

  // ----------------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------------
  // Low result selects the upper reference, high result the lower one.
  function automatic logic [11:0] pick_ref(input logic res, input logic [11:0] lo, input logic [11:0] up);
    pick_ref = res ? lo : up;
  endfunction

  logic running;
  assign running = (seq_r == lcs_pkg::SEQ_RUN) && !cur.stop;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog_out <= '0;
      latch_strobe <= 1'b0;
    end else if (!running) begin
      analog_out <= '0; // [R18] [R13]
      latch_strobe <= 1'b0;
    end else begin
      analog_out.excite <= cur.excite; // [R6]
      analog_out.damp_short <= !cur.undamped; // [R11]
      analog_out.comparator_on <= cur.comparator_on; // [R9] [R7]
      analog_out.dac_on <= cur.dac_on; // [R9] [R10]
      analog_out.chan <= cur.chan; // [R12]
      analog_out.dac_level <= pick_ref(result_r[cur.chan[0]], lower_r[cur.chan[0]], upper_r[cur.chan[0]]); // [R17]
      latch_strobe <= latch_now; // [R10]
    end
  end

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  logic [1:0] new_result;
  always_comb begin
    new_result = result_r;
    if (latch_now) begin
      new_result[cur.chan[0]] = comp_sample;
    end
  end

  assign evt_set = {new_result[1] != result_r[1], new_result[0] != result_r[0], scan_end};

  // A set in the same cycle as its clear wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_status_r <= lcs_pkg::EVT_RST;
    end else begin
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set; // [R3]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scan_stop <= 1'b0;
    end else begin
      scan_stop <= scan_end; // [R3] [R13]
    end
  end

  // The interrupt follows the status value written at this same edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((evt_status_r & ~evt_clr) | evt_set) & irq_en_r);
    end
  end

  assign chan_result = result_r;

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (is_state_addr(reg_addr)) begin
      reg_rdata <= state_mem_r[reg_addr[4:0]];
    end else begin
      case (reg_addr)
        lcs_pkg::ADDR_CTRL: reg_rdata <= ctrl_r;
        lcs_pkg::ADDR_PERIOD: reg_rdata <= period_r;
        lcs_pkg::ADDR_LOWER0: reg_rdata <= {4'h0, lower_r[0]};
        lcs_pkg::ADDR_UPPER0: reg_rdata <= {4'h0, upper_r[0]};
        lcs_pkg::ADDR_LOWER1: reg_rdata <= {4'h0, lower_r[1]};
        lcs_pkg::ADDR_UPPER1: reg_rdata <= {4'h0, upper_r[1]};
        lcs_pkg::ADDR_STATUS: reg_rdata <= {13'h0000, evt_status_r};
        lcs_pkg::ADDR_IRQ_EN: reg_rdata <= {13'h0000, irq_en_r};
        lcs_pkg::ADDR_RUN_INFO: reg_rdata <= {6'h00, seq_r, result_r, idx_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule

//--- core/lcs_pkg.sv
// Shared constants and types for the LC sensor scan sequencer.
package lcs_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int NUM_STATES = 32;
  localparam int NUM_CHAN = 2;
  localparam int DAC_W = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_EVT = 3;

  // ----------------------------------------------------------------------
  // Register word addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATE_BASE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_TRIGGER = 8'h21;
  localparam logic [7:0] ADDR_PERIOD = 8'h22;
  localparam logic [7:0] ADDR_LOWER0 = 8'h23;
  localparam logic [7:0] ADDR_UPPER0 = 8'h24;
  localparam logic [7:0] ADDR_LOWER1 = 8'h25;
  localparam logic [7:0] ADDR_UPPER1 = 8'h26;
  localparam logic [7:0] ADDR_STATUS = 8'h27;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h28;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h29;
  localparam logic [7:0] ADDR_RUN_INFO = 8'h2A;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_INVERT = 2;
  localparam int TRIG_START = 0;
  localparam int EVT_STOP = 0;
  localparam int EVT_CH0 = 1;
  localparam int EVT_CH1 = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0040;
  localparam logic [11:0] DAC_RST = 12'h000;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [4:0] IDX_RST = 5'h00;
  localparam logic [15:0] STOP_WORD = 16'h0200;

  localparam logic [15:0] STATE_RST [0:NUM_STATES-1] = '{
    16'h0400, 16'h202C, 16'h0404, 16'h0024, 16'h0024, 16'h0024, 16'h0024, 16'h0024,
    16'h0024, 16'hF134, 16'h5974, 16'h0400, 16'h0400, 16'h20AD, 16'h0485, 16'h00A5,
    16'h00A5, 16'h00A5, 16'h00A5, 16'h00A5, 16'h00A5, 16'hF1B5, 16'h59F5, 16'h0200,
    16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200
  };

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] duration;
    logic aux_clk_sel;
    logic stop;
    logic dac_on;
    logic reserved;
    logic latch_en;
    logic hf_clk_sel;
    logic comparator_on;
    logic excite;
    logic undamped;
    logic [1:0] chan;
  } lcs_state_word_t;

  typedef struct packed {
    logic excite;
    logic damp_short;
    logic comparator_on;
    logic dac_on;
    logic [1:0] chan;
    logic [11:0] dac_level;
  } lcs_analog_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN = 3'b010,
    SEQ_WAIT = 3'b100
  } lcs_seq_t;

endpackage

//--- tb/lcs_scan_sequencer_assertions.sv
// Concurrent checks on the ports of the LC sensor scan sequencer.
module lcs_scan_sequencer_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic aux_clk_in,
  input wire logic sense_osc_clock,
  input wire logic fast_sense_clock,
  input wire logic comparator_in,
  input wire lcs_pkg::lcs_analog_t analog_out,
  input wire logic latch_strobe,
  input wire logic scan_stop,
  input wire logic [1:0] chan_result,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_n |=> analog_out == '0 && !scan_stop && !irq)
    else $error("outputs active after reset");
  AST_STOP_PULSE: assert property (scan_stop |=> !scan_stop [*8])
    else $error("stop pulse longer than one cycle");
  AST_STOP_OUT_ZERO: assert property (scan_stop |-> analog_out == '0)
    else $error("analog controls on at scan end");
  AST_LATCH_PULSE: assert property (latch_strobe |=> !latch_strobe)
    else $error("latch strobe longer than one cycle");
  AST_RESULT_ON_LATCH: assert property (!$stable(chan_result) |-> ($past(latch_strobe) || latch_strobe) or (##1 latch_strobe))
    else $error("result changed without a latch");
  AST_LATCH_COMP_ON: assert property (latch_strobe |-> $past(analog_out.comparator_on) || analog_out.comparator_on)
    else $error("latch without comparator on");
  AST_TRIG_RD_ZERO: assert property (reg_rd && reg_addr == lcs_pkg::ADDR_TRIGGER |=> reg_rdata == 16'h0000)
    else $error("trigger register read not zero");
  AST_IRQ_MASKED: assert property (reg_wr && reg_addr == lcs_pkg::ADDR_IRQ_EN && reg_wdata[2:0] == 3'h0
    ##1 !(reg_wr && reg_addr == lcs_pkg::ADDR_IRQ_EN) |=> !irq)
    else $error("interrupt high while masked");
  AST_EXCITE_ALONE: assert property (analog_out.excite |-> !analog_out.comparator_on && !analog_out.dac_on)
    else $error("excitation with analog parts on");
  AST_DAMP_OFF: assert property (analog_out.damp_short |-> !analog_out.comparator_on && !analog_out.excite)
    else $error("damping with comparator or excitation on");
  AST_COMP_WITH_DAC: assert property (analog_out.comparator_on |-> analog_out.dac_on)
    else $error("comparator on without reference");

  COV_STOP: cover property (scan_stop);
  COV_LATCH: cover property (latch_strobe);
  COV_IRQ: cover property ($rose(irq));
endmodule

bind lcs_scan_sequencer lcs_scan_sequencer_chk u_lcs_scan_sequencer_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .aux_clk_in(aux_clk_in), .sense_osc_clock(sense_osc_clock), .fast_sense_clock(fast_sense_clock),
  .comparator_in(comparator_in), .analog_out(analog_out), .latch_strobe(latch_strobe),
  .scan_stop(scan_stop), .chan_result(chan_result), .irq(irq));

//--- tb/lcs_sensor_model.sv
// Behavioural model of two LC sensors, their comparator and the clock sources.
module lcs_sensor_model (
  input wire lcs_pkg::lcs_analog_t analog_out,
  input wire logic [11:0] level0,
  input wire logic [11:0] level1,
  output logic aux_clk_in,
  output logic sense_osc_clock,
  output logic fast_sense_clock,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] sig;

  // Half periods are chosen so no source shares phase with the system clock.
  initial begin
    aux_clk_in = 1'b0;
    sense_osc_clock = 1'b0;
    fast_sense_clock = 1'b0;
    comparator_in = 1'b0;
  end
  always #1013 aux_clk_in = ~aux_clk_in;
  always #437 sense_osc_clock = ~sense_osc_clock;
  always #311 fast_sense_clock = ~fast_sense_clock;

  // An unpowered comparator gives no valid answer, so it toggles.
  assign sig = analog_out.chan[0] ? level1 : level0;
  always @(posedge fast_sense_clock) begin
    if (analog_out.comparator_on && analog_out.dac_on) begin
      comparator_in <= sig > analog_out.dac_level;
    end else begin
      comparator_in <= ~comparator_in;
    end
  end
endmodule

//--- tb/lcs_scan_sequencer_tb_top.sv
// Self-checking bench for the LC sensor scan sequencer.
module lcs_scan_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [15:0] e;} lcs_row_t;
  logic clk, rst_n, reg_wr, reg_rd, latch_strobe, scan_stop, irq, damp_seen;
  logic aux_clk_in, sense_osc_clock, fast_sense_clock, comparator_in;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [1:0] chan_result, exc_seen;
  logic [11:0] level0, level1, dac0;
  lcs_pkg::lcs_analog_t analog_out;
  int error_cnt, n_tests, lat_cnt, stop_cnt, c;
  lcs_row_t rows [10] = '{'{8'h00, 16'h0400}, '{8'h01, 16'h202C}, '{8'h09, 16'hF134}, '{8'h0A, 16'h5974},
    '{8'h0D, 16'h20AD}, '{8'h17, 16'h0200}, '{8'h20, 16'h0000}, '{8'h22, 16'h0040}, '{8'h21, 16'h0000},
    '{8'h3F, 16'h0000}};

  lcs_scan_sequencer u_lcs_scan_sequencer (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_clk_in(aux_clk_in),
    .sense_osc_clock(sense_osc_clock), .fast_sense_clock(fast_sense_clock), .comparator_in(comparator_in),
    .analog_out(analog_out), .latch_strobe(latch_strobe), .scan_stop(scan_stop), .chan_result(chan_result),
    .irq(irq));
  lcs_sensor_model u_lcs_sensor_model (.analog_out(analog_out), .level0(level0), .level1(level1),
    .aux_clk_in(aux_clk_in), .sense_osc_clock(sense_osc_clock), .fast_sense_clock(fast_sense_clock),
    .comparator_in(comparator_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_stop();
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (scan_stop !== 1'b1 && c < 4000);
    chk(c < 4000, 1'b1);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Records what each scan drove, for checking after the scan ends.
  always @(posedge clk) begin
    if (analog_out.excite === 1'b1) exc_seen[analog_out.chan[0]] <= 1'b1;
    if (analog_out.damp_short === 1'b1) damp_seen <= 1'b1;
    if (latch_strobe === 1'b1) lat_cnt <= lat_cnt + 1;
    if (scan_stop === 1'b1) stop_cnt <= stop_cnt + 1;
    if (analog_out.dac_on === 1'b1 && analog_out.chan[0] === 1'b0) dac0 <= analog_out.dac_level;
  end

  initial begin
    #5000000;
    error_cnt++;
    stop_test();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, exc_seen, damp_seen, dac0} = '0;
    {error_cnt, n_tests, lat_cnt, stop_cnt} = '0;
    level0 = 12'h800;
    level1 = 12'h000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk({analog_out, scan_stop, irq, latch_strobe, chan_result}, '0);
    for (int i = 0; i < 10; i++) begin
      rd(rows[i].a);
      chk(d, rows[i].e);
    end
    wr(8'h3F, 16'hFFFF);
    rd(8'h3F);
    chk(d, 16'h0000);
    wr(lcs_pkg::ADDR_LOWER0, 16'hF123);
    wr(lcs_pkg::ADDR_UPPER0, 16'h07FF);
    rd(lcs_pkg::ADDR_LOWER0);
    chk(d, 16'h0123);
    $display("register test done");
    wr(lcs_pkg::ADDR_IRQ_EN, 16'h0001);
    wr(lcs_pkg::ADDR_CTRL, 16'h0001);
    repeat (300) @(posedge clk);
    rd(lcs_pkg::ADDR_RUN_INFO);
    chk({d[9:7], exc_seen}, 5'b00100);
    wr(lcs_pkg::ADDR_TRIGGER, 16'h0001);
    wait_stop();
    chk({exc_seen, damp_seen, lat_cnt[1:0], dac0}, {2'b11, 1'b1, 2'd2, 12'h7FF});
    chk(chan_result, 2'b01);
    rd(lcs_pkg::ADDR_STATUS);
    chk({d, irq}, {16'h0003, 1'b1});
    wr(lcs_pkg::ADDR_IRQ_CLR, 16'h0007);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("triggered scan test done");
    wr(lcs_pkg::ADDR_TRIGGER, 16'h0001);
    repeat (50) @(posedge clk);
    wr(lcs_pkg::ADDR_TRIGGER, 16'h0001);
    wait_stop();
    chk(dac0, 12'h123);
    repeat (1500) @(posedge clk);
    chk(stop_cnt, 2);
    $display("refused trigger test done");
    wr(lcs_pkg::ADDR_PERIOD, 16'h0002);
    wr(lcs_pkg::ADDR_CTRL, 16'h0007);
    wait_stop();
    chk(chan_result, 2'b10);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (analog_out.excite !== 1'b1 && c < 500);
    chk(c >= 40 && c <= 110, 1'b1);
    $display("auto repeat test done");
    wr(lcs_pkg::ADDR_CTRL, 16'h0000);
    repeat (3000) @(posedge clk);
    rd(lcs_pkg::ADDR_RUN_INFO);
    chk({d[9:7], analog_out}, {3'b001, 18'h0});
    chk(irq, 1'b1);
    wr(lcs_pkg::ADDR_IRQ_EN, 16'h0000);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h01, 16'h1234);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h01);
    chk(d, 16'h202C);
    $display("idle and reset test done");
    stop_test();
  end
endmodule
